// ---- hdl/pmic_fabric.sv ----
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module pmic_slice #(
	parameter bit EN = 1'b0,
	parameter int W = 1
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic arst_n,
	// Upstream
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	// Downstream
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	generate
		if (EN) begin : g_reg
			logic valid_q;
			logic [W-1:0] data_q;
			// Holds while stalled; refills in the same cycle it drains
			assign in_ready = !valid_q || out_ready;
			assign out_valid = valid_q;
			assign out_data = data_q;
			always_ff @(posedge sys_clk or negedge arst_n) begin
				if (!arst_n) begin
					valid_q <= 1'b0;
				end else if (in_ready) begin
					valid_q <= in_valid;
				end
			end
			always_ff @(posedge sys_clk) begin
				if (in_ready && in_valid) begin
					data_q <= in_data;
				end
			end
		end else begin : g_wire
			assign in_ready = out_ready;
			assign out_valid = in_valid;
			assign out_data = in_data;
		end
	endgenerate
endmodule

////////////////////////////////////////////////////////////////////////////////
module pmic_fabric #(
	parameter int NUM_M = 2,
	parameter int NUM_S = 2,
	parameter int PIPE_LIMIT = 0,
	parameter bit ECC_EN = 1'b1
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic arst_n,
	// Master side
	input wire logic [NUM_M-1:0] m_cmd_valid,
	output logic [NUM_M-1:0] m_cmd_ready,
	input wire pmic_pkg::pmic_cmd_type [NUM_M-1:0] m_cmd,
	output logic [NUM_M-1:0] m_rsp_valid,
	input wire logic [NUM_M-1:0] m_rsp_ready,
	output pmic_pkg::pmic_rsp_type m_rsp,
	// Slave side
	output logic [NUM_S-1:0] s_cmd_valid,
	input wire logic [NUM_S-1:0] s_cmd_ready,
	output pmic_pkg::pmic_cmd_type s_cmd,
	input wire logic [NUM_S-1:0] s_rsp_valid,
	output logic [NUM_S-1:0] s_rsp_ready,
	input wire pmic_pkg::pmic_rsp_type [NUM_S-1:0] s_rsp,
	// Fault injection into stored buffer words
	input wire logic [pmic_pkg::ECC_W-1:0] ecc_flip
);
	localparam int CW = $bits(pmic_pkg::pmic_cmd_type);
	localparam int RW = $bits(pmic_pkg::pmic_rsp_type);
	localparam int LIM = (PIPE_LIMIT > pmic_pkg::MAX_STAGES) ? pmic_pkg::MAX_STAGES : PIPE_LIMIT;
	localparam bit ONE_ONE = (NUM_M == 1) && (NUM_S == 1);
	// A position exists only where its component does; stages fill in order up to the limit
	localparam bit P_DMX_IN = !ONE_ONE && (NUM_S > 1) && (LIM >= 1);
	localparam int N0 = P_DMX_IN ? 1 : 0;
	localparam bit P_MUX_OUT = !ONE_ONE && (NUM_S > 1) && (LIM > N0);
	localparam int N1 = N0 + (P_MUX_OUT ? 1 : 0);
	localparam bit P_ARB_MUX = !ONE_ONE && (NUM_M > 1) && (LIM > N1);
	localparam int N2 = N1 + (P_ARB_MUX ? 1 : 0);
	localparam bit P_DMX_OUT = !ONE_ONE && (NUM_S > 1) && (LIM > N2);

	////////////////////////////////////////////////////////////////////////////
	function automatic logic [pmic_pkg::ECC_W-1:0] ecc_encode(input logic [pmic_pkg::DATA_W-1:0] d);
		logic [pmic_pkg::ECC_W-1:0] cw;
		int k;
		cw = '0;
		k = 0;
		for (int p = 1; p < pmic_pkg::ECC_W; p++) begin
			if ((p & (p - 1)) != 0) begin
				cw[p] = d[k];
				k++;
			end
		end
		for (int b = 0; b < pmic_pkg::SYN_W; b++) begin
			for (int p = 1; p < pmic_pkg::ECC_W; p++) begin
				if (((p & (p - 1)) != 0) && (((p >> b) & 1) == 1)) begin
					cw[1 << b] = cw[1 << b] ^ cw[p];
				end
			end
		end
		cw[0] = ^cw;
		return cw;
	endfunction

	// Returns {uncorrectable, data}; single flips repaired, double flips flagged
	function automatic logic [pmic_pkg::DATA_W:0] ecc_decode(input logic [pmic_pkg::ECC_W-1:0] w);
		logic [pmic_pkg::ECC_W-1:0] c;
		logic [pmic_pkg::SYN_W-1:0] syn;
		logic [pmic_pkg::DATA_W-1:0] d;
		logic unc;
		int k;
		c = w;
		syn = '0;
		unc = 1'b0;
		d = '0;
		k = 0;
		for (int p = 1; p < pmic_pkg::ECC_W; p++) begin
			if (c[p]) begin
				syn = syn ^ pmic_pkg::SYN_W'(p);
			end
		end
		if (syn != '0) begin
			if ((^c) && (int'(syn) < pmic_pkg::ECC_W)) begin
				c[syn] = ~c[syn];
			end else begin
				unc = 1'b1;
			end
		end
		for (int p = 1; p < pmic_pkg::ECC_W; p++) begin
			if ((p & (p - 1)) != 0) begin
				d[k] = c[p];
				k++;
			end
		end
		return {unc, d};
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Arbiter: one transaction outstanding keeps responses in command order
	pmic_pkg::pmic_state_type state_q;
	logic [NUM_M-1:0] owner_q;
	logic [NUM_M-1:0] last_q;
	logic [NUM_M-1:0] pick;
	logic [NUM_S-1:0] tgt_q;
	logic arb_valid, arb_ready;
	pmic_pkg::pmic_cmd_type arb_cmd;
	logic m_rsp_done;

	// Search starts just past the last grant, so the other master wins a tie
	always_comb begin
		int idx;
		int pos;
		idx = 0;
		pos = 0;
		pick = '0;
		for (int j = 0; j < NUM_M; j++) begin
			if (last_q[j]) begin
				pos = j;
			end
		end
		for (int i = NUM_M; i >= 1; i--) begin
			idx = (i + pos) % NUM_M;
			if (m_cmd_valid[idx]) begin
				pick = '0;
				pick[idx] = 1'b1;
			end
		end
	end

	always_comb begin
		arb_cmd = '0;
		for (int i = 0; i < NUM_M; i++) begin
			if (pick[i]) begin
				arb_cmd = m_cmd[i];
			end
		end
	end

	assign arb_valid = (state_q == pmic_pkg::PMIC_IDLE) && (pick != '0);
	assign m_cmd_ready = (arb_valid && arb_ready) ? pick : '0;
	assign m_rsp_done = |(m_rsp_valid & m_rsp_ready);

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			state_q <= pmic_pkg::PMIC_IDLE;
			owner_q <= '0;
			last_q <= '0;
		end else begin
			case (state_q)
				pmic_pkg::PMIC_IDLE: begin
					if (arb_valid && arb_ready) begin
						state_q <= pmic_pkg::PMIC_BUSY;
						owner_q <= pick;
						last_q <= pick;
					end
				end
				pmic_pkg::PMIC_BUSY: begin
					if (m_rsp_done) begin
						state_q <= pmic_pkg::PMIC_IDLE;
					end
				end
				default: state_q <= pmic_pkg::PMIC_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Command path: all its stages stack in one series chain
	logic c1_valid, c1_ready, c2_valid, c2_ready, c3_valid, c3_ready;
	logic [CW-1:0] c1_data, c2_data, c3_data;
	logic sel;

	pmic_slice #(.EN(P_ARB_MUX), .W(CW)) u_arb_mux (
		.sys_clk(sys_clk), .arst_n(arst_n),
		.in_valid(arb_valid), .in_ready(arb_ready), .in_data(arb_cmd),
		.out_valid(c1_valid), .out_ready(c1_ready), .out_data(c1_data)
	);
	pmic_slice #(.EN(P_DMX_IN), .W(CW)) u_dmx_in (
		.sys_clk(sys_clk), .arst_n(arst_n),
		.in_valid(c1_valid), .in_ready(c1_ready), .in_data(c1_data),
		.out_valid(c2_valid), .out_ready(c2_ready), .out_data(c2_data)
	);
	pmic_slice #(.EN(P_DMX_OUT), .W(CW)) u_dmx_out (
		.sys_clk(sys_clk), .arst_n(arst_n),
		.in_valid(c2_valid), .in_ready(c2_ready), .in_data(c2_data),
		.out_valid(c3_valid), .out_ready(c3_ready), .out_data(c3_data)
	);

	assign s_cmd = c3_data;
	assign sel = (NUM_S > 1) ? s_cmd.addr[pmic_pkg::SEL_BIT] : 1'b0;
	always_comb begin
		s_cmd_valid = '0;
		s_cmd_valid[sel] = c3_valid;
	end
	assign c3_ready = s_cmd_ready[sel];

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			tgt_q <= '0;
		end else if (c3_valid && c3_ready) begin
			tgt_q <= '0;
			tgt_q[sel] <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Response path: slave mux, then the read-data buffer, the only protected storage
	pmic_pkg::pmic_fifo_type mem [pmic_pkg::FIFO_DEPTH];
	logic [pmic_pkg::PTR_W:0] wr_q, rd_q;
	logic f_full, f_empty, f_in_valid, f_out_ready, f_push, f_pop;
	pmic_pkg::pmic_rsp_type f_in, f_out;
	logic [pmic_pkg::DATA_W:0] dec;
	pmic_pkg::pmic_fifo_type head;

	always_comb begin
		f_in = '0;
		f_in_valid = 1'b0;
		for (int i = 0; i < NUM_S; i++) begin
			if (tgt_q[i]) begin
				f_in = s_rsp[i];
				f_in_valid = s_rsp_valid[i];
			end
		end
	end

	assign f_full = (wr_q[pmic_pkg::PTR_W] != rd_q[pmic_pkg::PTR_W]) &&
		(wr_q[pmic_pkg::PTR_W-1:0] == rd_q[pmic_pkg::PTR_W-1:0]);
	assign f_empty = (wr_q == rd_q);
	assign s_rsp_ready = f_full ? '0 : tgt_q;
	assign f_push = f_in_valid && !f_full;
	assign f_pop = !f_empty && f_out_ready;

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			wr_q <= '0;
			rd_q <= '0;
		end else begin
			if (f_push) begin
				wr_q <= wr_q + 1'b1;
			end
			if (f_pop) begin
				rd_q <= rd_q + 1'b1;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (f_push) begin
			mem[wr_q[pmic_pkg::PTR_W-1:0]].resp <= f_in.resp;
			mem[wr_q[pmic_pkg::PTR_W-1:0]].word <= (ECC_EN ? ecc_encode(f_in.rdata) :
				{{(pmic_pkg::ECC_W-pmic_pkg::DATA_W){1'b0}}, f_in.rdata}) ^ ecc_flip;
		end
	end

	assign head = mem[rd_q[pmic_pkg::PTR_W-1:0]];
	assign dec = ECC_EN ? ecc_decode(head.word) : {1'b0, head.word[pmic_pkg::DATA_W-1:0]};
	assign f_out.rdata = dec[pmic_pkg::DATA_W-1:0];
	assign f_out.resp = dec[pmic_pkg::DATA_W] ? pmic_pkg::RESP_DECERR : head.resp;

	logic r_valid, r_ready;
	logic [RW-1:0] r_data;
	pmic_slice #(.EN(P_MUX_OUT), .W(RW)) u_mux_out (
		.sys_clk(sys_clk), .arst_n(arst_n),
		.in_valid(!f_empty), .in_ready(f_out_ready), .in_data(f_out),
		.out_valid(r_valid), .out_ready(r_ready), .out_data(r_data)
	);

	assign m_rsp = r_data;
	assign m_rsp_valid = r_valid ? owner_q : '0;
	assign r_ready = |(owner_q & m_rsp_ready);
endmodule

// ---- hdl/pmic_pkg.sv ----
// Contract
// - Stage limit is zero to four; zero gives a combinational command path, with only the buffer registering responses.
// - Pipelining adds latency up to three times on the command path and once on response.
// - With one slave there is no multiplexer, so no multiplexer register.
// - One master joined to one slave gets no stages, whatever the limit.
// - Four candidate positions: demux input, mux output, arbiter-mux, demux output.
// - Error correction covers only the read-data response buffer.
// - Protected buffer Hamming-encodes words on entry, decodes and checks on exit.
// - Repairable errors are corrected so delivered data equals written data.
// - An unrepairable error returns the decode-error response code for that read.
package pmic_pkg;
	localparam int ADDR_W = 32;
	localparam int DATA_W = 32;
	localparam int RESP_W = 2;
	localparam int ECC_W = 39;
	localparam int SYN_W = 6;
	localparam int MAX_STAGES = 4;
	localparam int FIFO_DEPTH = 4;
	localparam int PTR_W = 2;
	localparam int SEL_BIT = 28;
	localparam logic [RESP_W-1:0] RESP_OKAY = 2'h0;
	localparam logic [RESP_W-1:0] RESP_DECERR = 2'h3;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic write;
		logic [DATA_W-1:0] wdata;
	} pmic_cmd_type;

	typedef struct packed {
		logic [RESP_W-1:0] resp;
		logic [DATA_W-1:0] rdata;
	} pmic_rsp_type;

	typedef struct packed {
		logic [RESP_W-1:0] resp;
		logic [ECC_W-1:0] word;
	} pmic_fifo_type;

	typedef enum logic [1:0] {
		PMIC_IDLE = 2'b01,
		PMIC_BUSY = 2'b10
	} pmic_state_type;
endpackage

// ---- bench/pmic_slave_model.sv ----
`timescale 1ns/1ps
module pmic_slave_model (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic arst_n,
	// Command in
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire pmic_pkg::pmic_cmd_type cmd,
	// Response out
	output logic rsp_valid,
	input wire logic rsp_ready,
	output pmic_pkg::pmic_rsp_type rsp,
	// Extra cycles before answering
	input wire logic [3:0] delay
);
	logic [31:0] mem_q [4];
	logic [31:0] data_q;
	logic [3:0] wait_q;
	logic pend_q;
	assign cmd_ready = !pend_q;
	assign rsp_valid = pend_q && wait_q == 4'h0;
	// Idle bus shows inverted data so a stale sample never matches
	assign rsp.resp = rsp_valid ? pmic_pkg::RESP_OKAY : 2'h2;
	assign rsp.rdata = rsp_valid ? data_q : ~data_q;
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			pend_q <= 1'b0;
			wait_q <= 4'h0;
			data_q <= 32'h0000_0000;
		end else if (cmd_valid && cmd_ready) begin
			pend_q <= 1'b1;
			wait_q <= delay;
			data_q <= cmd.write ? cmd.wdata : mem_q[cmd.addr[3:2]];
		end else if (rsp_valid && rsp_ready) begin
			pend_q <= 1'b0;
		end else if (wait_q != 4'h0) begin
			wait_q <= wait_q - 4'h1;
		end
	end
	always_ff @(posedge sys_clk) begin
		if (cmd_valid && cmd_ready && cmd.write) begin
			mem_q[cmd.addr[3:2]] <= cmd.wdata;
		end
	end
endmodule

// ---- bench/pmic_fabric_chk.sv ----
`timescale 1ns/1ps
module pmic_fabric_chk #(
	parameter int NUM_M = 2,
	parameter int NUM_S = 2
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic arst_n,
	// Master side
	input wire logic [NUM_M-1:0] m_cmd_valid,
	input wire logic [NUM_M-1:0] m_cmd_ready,
	input wire pmic_pkg::pmic_cmd_type [NUM_M-1:0] m_cmd,
	input wire logic [NUM_M-1:0] m_rsp_valid,
	input wire logic [NUM_M-1:0] m_rsp_ready,
	input wire pmic_pkg::pmic_rsp_type m_rsp,
	// Slave side
	input wire logic [NUM_S-1:0] s_cmd_valid,
	input wire pmic_pkg::pmic_cmd_type s_cmd,
	input wire logic [NUM_S-1:0] s_rsp_valid,
	input wire logic [NUM_S-1:0] s_rsp_ready,
	input wire pmic_pkg::pmic_rsp_type [NUM_S-1:0] s_rsp,
	input wire logic [pmic_pkg::ECC_W-1:0] ecc_flip
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!arst_n);
	wire cmd_hs = |(m_cmd_valid & m_cmd_ready);
	wire rsp_hs = |(m_rsp_valid & m_rsp_ready);
	wire s0_hs = s_rsp_valid[0] && s_rsp_ready[0];
	// Set from grant until the owner's response handshake
	logic busy_q;
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			busy_q <= 1'b0;
		end else if (rsp_hs) begin
			busy_q <= 1'b0;
		end else if (cmd_hs) begin
			busy_q <= 1'b1;
		end
	end
	a_grant_onehot: assert property ($onehot0(m_cmd_valid & m_cmd_ready)) else $error("two grants");
	a_cmd_comb: assert property (m_cmd_valid[0] && m_cmd_ready[0] |->
		s_cmd_valid[m_cmd[0].addr[pmic_pkg::SEL_BIT]] && s_cmd == m_cmd[0]) else $error("command not passed through");
	a_single_txn: assert property (busy_q |-> !cmd_hs) else $error("grant while busy");
	a_rsp_bound: assert property (cmd_hs |-> ##[1:30] rsp_hs) else $error("response missing");
	a_rsp_hold: assert property (|(m_rsp_valid & ~m_rsp_ready) |=>
		m_rsp_valid == $past(m_rsp_valid) && $stable(m_rsp)) else $error("response dropped");
	a_rsp_after: assert property (|(s_rsp_valid & s_rsp_ready) |=> $onehot(m_rsp_valid)) else $error("late response");
	a_data_fixed: assert property (s0_hs && $countones(ecc_flip) < 2 |=>
		m_rsp == $past(s_rsp[0])) else $error("read data altered");
	a_double_err: assert property (s0_hs && $countones(ecc_flip) == 2 |=>
		m_rsp.resp == pmic_pkg::RESP_DECERR) else $error("double error not flagged");
	a_rsp_onehot: assert property ($onehot0(m_rsp_valid)) else $error("two responses");
	c_both_req: cover property (&m_cmd_valid);
	c_stall: cover property (m_rsp_valid[0] && !m_rsp_ready[0]);
	c_decerr: cover property (|m_rsp_valid && m_rsp.resp == pmic_pkg::RESP_DECERR);
endmodule

// ---- bench/pipelined_mm_interconnect_ecc_test.sv ----
`timescale 1ns/1ps
module pipelined_mm_interconnect_ecc_test;
	logic sys_clk, arst_n;
	logic [1:0] m_cmd_valid, m_cmd_ready, m_rsp_valid, m_rsp_ready;
	logic [1:0] s_cmd_valid, s_cmd_ready, s_rsp_valid, s_rsp_ready;
	pmic_pkg::pmic_cmd_type [1:0] m_cmd;
	pmic_pkg::pmic_cmd_type s_cmd;
	pmic_pkg::pmic_rsp_type m_rsp;
	pmic_pkg::pmic_rsp_type [1:0] s_rsp;
	logic [pmic_pkg::ECC_W-1:0] ecc_flip;
	logic [3:0] delay [2];
	int bad_count, comparisons;
	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end
	pmic_fabric #(.NUM_M(2), .NUM_S(2), .PIPE_LIMIT(0), .ECC_EN(1'b1)) u_pmic_fabric (.sys_clk(sys_clk),
		.arst_n(arst_n), .m_cmd_valid(m_cmd_valid), .m_cmd_ready(m_cmd_ready), .m_cmd(m_cmd),
		.m_rsp_valid(m_rsp_valid), .m_rsp_ready(m_rsp_ready), .m_rsp(m_rsp), .s_cmd_valid(s_cmd_valid),
		.s_cmd_ready(s_cmd_ready), .s_cmd(s_cmd), .s_rsp_valid(s_rsp_valid), .s_rsp_ready(s_rsp_ready),
		.s_rsp(s_rsp), .ecc_flip(ecc_flip));
	for (genvar g = 0; g < 2; g++) begin : g_slv
		pmic_slave_model u_pmic_slave_model (.sys_clk(sys_clk), .arst_n(arst_n), .cmd_valid(s_cmd_valid[g]),
			.cmd_ready(s_cmd_ready[g]), .cmd(s_cmd), .rsp_valid(s_rsp_valid[g]), .rsp_ready(s_rsp_ready[g]),
			.rsp(s_rsp[g]), .delay(delay[g]));
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic check(string nm, logic [33:0] e, logic [33:0] g);
		comparisons++;
		if (g !== e) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic start(int i, logic w, logic [31:0] a, logic [31:0] d);
		m_cmd[i] = '{addr: a, write: w, wdata: d};
		m_cmd_valid[i] = 1'b1;
	endtask
	// Response ready is held low for st cycles to stall the return path
	task automatic finish(int i, logic [1:0] er, logic [31:0] ed, int st);
		int n;
		n = 0;
		#1;
		while (m_cmd_ready[i] !== 1'b1 && n < 50) begin
			@(negedge sys_clk);
			#1;
			n++;
		end
		check("cmd_ready", 34'h1, m_cmd_ready[i]);
		@(negedge sys_clk);
		m_cmd_valid[i] = 1'b0;
		m_rsp_ready[i] = (st == 0);
		#1;
		while (m_rsp_valid[i] !== 1'b1 && n < 100) begin
			@(negedge sys_clk);
			#1;
			n++;
		end
		repeat (st) @(negedge sys_clk);
		check("rsp_valid", 34'h1, m_rsp_valid[i]);
		m_rsp_ready[i] = 1'b1;
		#1;
		check("resp", er, m_rsp.resp);
		if (er == pmic_pkg::RESP_OKAY) check("rdata", ed, m_rsp.rdata);
		@(negedge sys_clk);
		m_rsp_ready[i] = 1'b0;
		#1;
		check("rsp_once", 34'h0, m_rsp_valid[i]);
	endtask
	task automatic txn(int i, logic w, logic [31:0] a, logic [31:0] d, logic [38:0] f, logic [1:0] er, int st);
		@(negedge sys_clk);
		ecc_flip = f;
		start(i, w, a, d);
		finish(i, er, w ? d : 32'hA5A5_0F0F, st);
		ecc_flip = '0;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task automatic wr_rd();
		delay[1] = 4'h3;
		txn(0, 1'b1, 32'h1000_0004, 32'hA5A5_0F0F, '0, pmic_pkg::RESP_OKAY, 0);
		txn(1, 1'b0, 32'h1000_0004, 32'h0000_0000, '0, pmic_pkg::RESP_OKAY, 0);
		txn(0, 1'b1, 32'h0000_0008, 32'hA5A5_0F0F, '0, pmic_pkg::RESP_OKAY, 0);
	endtask
	task automatic ecc_scan();
		logic [38:0] f [4];
		f = '{39'h00_0000_0001, 39'h00_0000_0010, 39'h00_0000_0008, 39'h00_0000_0028};
		for (int k = 0; k < 4; k++) begin
			txn(0, 1'b0, 32'h0000_0008, 32'h0000_0000, f[k], k == 3 ? 2'h3 : 2'h0, 0);
		end
	endtask
	// Master 0 was served last, so master 1 must win the tie
	task automatic rr_pick();
		@(negedge sys_clk);
		start(0, 1'b0, 32'h0000_0008, 32'h0000_0000);
		start(1, 1'b0, 32'h1000_0004, 32'h0000_0000);
		finish(1, pmic_pkg::RESP_OKAY, 32'hA5A5_0F0F, 0);
		finish(0, pmic_pkg::RESP_OKAY, 32'hA5A5_0F0F, 0);
	endtask
	task automatic stop_test();
		if (bad_count == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial begin
		#100000;
		bad_count++;
		stop_test();
	end
	initial begin
		arst_n = 1'b0;
		m_cmd_valid = '0;
		m_cmd = '0;
		m_rsp_ready = '0;
		ecc_flip = '0;
		delay = '{4'h0, 4'h0};
		repeat (6) @(posedge sys_clk);
		@(negedge sys_clk);
		arst_n = 1'b1;
		wr_rd();
		ecc_scan();
		rr_pick();
		txn(1, 1'b0, 32'h1000_0004, 32'h0000_0000, '0, pmic_pkg::RESP_OKAY, 3);
		stop_test();
	end
endmodule
bind pmic_fabric pmic_fabric_chk #(.NUM_M(NUM_M), .NUM_S(NUM_S)) u_pmic_fabric_chk (.sys_clk(sys_clk),
	.arst_n(arst_n), .m_cmd_valid(m_cmd_valid), .m_cmd_ready(m_cmd_ready), .m_cmd(m_cmd),
	.m_rsp_valid(m_rsp_valid), .m_rsp_ready(m_rsp_ready), .m_rsp(m_rsp), .s_cmd_valid(s_cmd_valid),
	.s_cmd(s_cmd), .s_rsp_valid(s_rsp_valid), .s_rsp_ready(s_rsp_ready), .s_rsp(s_rsp), .ecc_flip(ecc_flip));
